// ### hdl/uhcis_bus_if.sv
`timescale 1ns/1ps

interface uhcis_bus_if;
    logic        cs_rd;
    logic        cs_wr;
    logic        is_rd;
    logic        is_wr;
    logic [31:0] wdata;

    modport decoder (
        output cs_rd,
        output cs_wr,
        output is_rd,
        output is_wr,
        output wdata
    );

    modport regs (
        input cs_rd,
        input cs_wr,
        input is_rd,
        input is_wr,
        input wdata
    );
endinterface

// ### hdl/uhcis_cmd_decode.sv
`timescale 1ns/1ps
`include "uhcis_map.svh"

module uhcis_cmd_decode (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        strobe,
    input  wire logic [7:0]  code,
    input  wire logic [31:0] data,
    uhcis_bus_if.decoder     bus
);
    import uhcis_pkg::*;

    uhcis_dec_t state_reg;
    uhcis_dec_t state_next;

    function automatic logic code_hit(input logic [7:0] c,
                                      input logic [7:0] want);
        code_hit = (c == want);
    endfunction

    // unknown codes decode to nothing and are simply dropped
    always_comb begin
        state_next       = state_reg;
        state_next.cs_rd = strobe &&
                           code_hit(code, `UHCIS_CODE_CS_RD); // RULE15
        state_next.cs_wr = strobe &&
                           code_hit(code, `UHCIS_CODE_CS_WR); // RULE15
        state_next.is_rd = strobe &&
                           code_hit(code, `UHCIS_CODE_IS_RD); // RULE16
        state_next.is_wr = strobe &&
                           code_hit(code, `UHCIS_CODE_IS_WR); // RULE16
        if (strobe) begin
            state_next.wdata = data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign bus.cs_rd = state_reg.cs_rd;
    assign bus.cs_wr = state_reg.cs_wr;
    assign bus.is_rd = state_reg.is_rd;
    assign bus.is_wr = state_reg.is_wr;
    assign bus.wdata = state_reg.wdata;
endmodule

// ### hdl/uhcis_map.svh
`ifndef UHCIS_MAP_SVH
`define UHCIS_MAP_SVH

// host bus command codes
`define UHCIS_CODE_CS_RD        8'h02
`define UHCIS_CODE_CS_WR        8'h82
`define UHCIS_CODE_IS_RD        8'h03
`define UHCIS_CODE_IS_WR        8'h83

// command/status fields
`define UHCIS_CS_RESET_BIT      0
`define UHCIS_CS_OVR_LSB        16
`define UHCIS_CS_OVR_MSB        17
`define UHCIS_CS_RESET_VALUE    32'h00000000

// event flag positions
`define UHCIS_IS_OVERRUN        0
`define UHCIS_IS_FRAME_BEGIN    2
`define UHCIS_IS_RESUME         3
`define UHCIS_IS_FATAL          4
`define UHCIS_IS_FRAME_WRAP     5
`define UHCIS_IS_ROOT_HUB       6
`define UHCIS_IS_MSB            6
`define UHCIS_IS_RESET_VALUE    7'h00
`define UHCIS_IS_LIVE_MASK      7'h6D

// enable word and frame number
`define UHCIS_IE_MASTER         31
`define UHCIS_FN_MSB            15
`define UHCIS_NUM_PORTS         2

// timing
`define UHCIS_CLK_NS            50
`define UHCIS_TICK_NS           1000
`define UHCIS_TICK_CYCLES       (`UHCIS_TICK_NS / `UHCIS_CLK_NS)
`define UHCIS_SRST_MAX_MS       10
`define UHCIS_SRST_TICKS        (`UHCIS_SRST_MAX_MS * 1000000 / `UHCIS_TICK_NS)

`endif

// ### hdl/uhcis_pkg.sv
`include "uhcis_map.svh"

package uhcis_pkg;

    typedef logic [`UHCIS_NUM_PORTS-1:0][31:0] uhcis_ports_t;

    typedef enum logic [1:0] {
        UHCIS_SR_IDLE = 2'b01,
        UHCIS_SR_BUSY = 2'b10
    } uhcis_srst_t;

    typedef struct packed {
        logic        cs_rd;
        logic        cs_wr;
        logic        is_rd;
        logic        is_wr;
        logic [31:0] wdata;
    } uhcis_dec_t;

    typedef struct packed {
        logic [4:0] count;
        logic       tick;
    } uhcis_tick_t;

    typedef struct packed {
        uhcis_srst_t  srst;
        logic [15:0]  srst_count;
        logic [1:0]   ovr_count;
        logic [`UHCIS_IS_MSB:0] flags;
        logic         primed;
        logic         fn_msb_prev;
        logic         resume_prev;
        logic [31:0]  hub_prev;
        uhcis_ports_t port_prev;
        logic         halt;
        logic         irq;
        logic [31:0]  rd_data;
        logic         rd_valid;
        logic         opreg_reset;
        logic         suspend_enter;
    } uhcis_state_t;

endpackage

// ### hdl/uhcis_tick.sv
`timescale 1ns/1ps
`include "uhcis_map.svh"

module uhcis_tick (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clear,
    output logic      tick
);
    import uhcis_pkg::*;

    localparam logic [4:0] LAST = 5'(`UHCIS_TICK_CYCLES - 1);

    uhcis_tick_t state_reg;
    uhcis_tick_t state_next;

    // clear restarts the phase so a timed span starts on a clean tick
    always_comb begin
        state_next      = state_reg;
        state_next.tick = 1'b0;
        if (clear) begin
            state_next.count = 5'h00;
        end else if (state_reg.count == LAST) begin
            state_next.count = 5'h00;
            state_next.tick  = 1'b1;
        end else begin
            state_next.count = state_reg.count + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tick = state_reg.tick;
endmodule

// ### hdl/uhcis_top.sv
// How it works
// (RULE1) two-bit overrun count at bits 17:16, resets zero, wraps
// (RULE2) count bumps on every overrun even with its flag already set
// (RULE3) frame end without periodic list done bumps count and sets flag 0
// (RULE4) reset bit starts soft reset: suspend entered, registers cleared
// (RULE5) soft reset completes within 10 ms, then reset bit clears itself
// (RULE6) soft reset leaves root hub alone and drives no port reset
// (RULE7) command/status writes set ones, ignore zeros; reads show everything
// (RULE8) events set their flag; hardware never clears a flag
// (RULE9) interrupt while an enabled flag is set and master gate is on
// (RULE10) writing one clears a flag, zero leaves it; writes never set
// (RULE11) root hub or port status change sets flag 6
// (RULE12) frame number bit 15 toggling either way sets flag 5
// (RULE13) system error halts processing until the controller is reset
// (RULE14) fatal system error flag always reads zero in this variant
// (RULE15) command/status read with code 02, written with code 82
// (RULE16) event flags read with code 03, written with code 83
// (RULE17) frame begin flag 2 set when the frame start token goes out
// (RULE18) resume flag 3 set on device resume onset, not software resume
// (RULE19) enable word bit 31 is the master interrupt gate
// (RULE20) reserved bits read zero and ignore writes
`timescale 1ns/1ps
`include "uhcis_map.svh"

module uhcis_top #(
    parameter int SRST_TICKS = `UHCIS_SRST_TICKS
) (
    input  wire logic                  CLK,
    input  wire logic                  RSTN,
    input  wire logic                  CMD_STROBE,
    input  wire logic [7:0]            CMD_CODE,
    input  wire logic [31:0]           WR_DATA,
    output logic [31:0]                RD_DATA,
    output logic                       RD_VALID,
    input  wire logic                  FRAME_END,
    input  wire logic                  PERIODIC_DONE,
    input  wire logic                  FRAME_START,
    input  wire logic [15:0]           FRAME_NUMBER,
    input  wire logic [31:0]           ROOT_HUB_STATUS,
    input  wire uhcis_pkg::uhcis_ports_t DOWNSTREAM_PORT_STATUS,
    input  wire logic                  RESUME_SIGNALING,
    input  wire logic                  SW_RESUME_CMD,
    input  wire logic                  SYSTEM_ERROR,
    input  wire logic [31:0]           IRQ_ENABLE,
    output logic                       IRQ,
    output logic                       OPREG_RESET,
    output logic                       SUSPEND_ENTER,
    output logic                       HALT
);
    import uhcis_pkg::*;

    localparam logic [15:0] SRST_LAST = 16'(SRST_TICKS - 1);

    logic [1:0]   rst_sync;
    logic         rst_n;
    logic         tick;
    logic         tick_clear;
    logic         hub_changed;
    logic [`UHCIS_NUM_PORTS-1:0] port_changed;
    uhcis_state_t state_reg;
    uhcis_state_t state_next;

    uhcis_bus_if bus ();

    // release of reset goes through two flops, assertion stays immediate
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    uhcis_cmd_decode u_decode (
        .clk    (CLK),
        .rst_n  (rst_n),
        .strobe (CMD_STROBE),
        .code   (CMD_CODE),
        .data   (WR_DATA),
        .bus    (bus.decoder)
    );

    uhcis_tick u_tick (
        .clk   (CLK),
        .rst_n (rst_n),
        .clear (tick_clear),
        .tick  (tick)
    );

    // the microsecond divider restarts when a soft reset begins
    assign tick_clear = (state_reg.srst == UHCIS_SR_IDLE) && bus.cs_wr &&
                        bus.wdata[`UHCIS_CS_RESET_BIT];

    assign hub_changed = state_reg.primed &&
                         (ROOT_HUB_STATUS != state_reg.hub_prev);

    genvar gi;
    generate
        for (gi = 0; gi < `UHCIS_NUM_PORTS; gi++) begin : g_port
            assign port_changed[gi] = state_reg.primed &&
                (DOWNSTREAM_PORT_STATUS[gi] != state_reg.port_prev[gi]);
        end
    endgenerate

    always_comb begin
        logic [`UHCIS_IS_MSB:0] set_v;
        logic [`UHCIS_IS_MSB:0] clr_v;
        logic [`UHCIS_IS_MSB:0] en_v;
        logic                   overrun;
        logic                   srst_start;
        logic [31:0]            cs_word;
        set_v      = '0;
        clr_v      = '0;
        en_v       = '0;
        overrun    = 1'b0;
        srst_start = 1'b0;
        cs_word    = '0;
        state_next = state_reg;
        state_next.rd_valid      = 1'b0;
        state_next.opreg_reset   = 1'b0;
        state_next.suspend_enter = 1'b0;

        // history for the change and edge detectors
        state_next.primed      = 1'b1;
        state_next.fn_msb_prev = FRAME_NUMBER[`UHCIS_FN_MSB];
        state_next.resume_prev = RESUME_SIGNALING;
        state_next.hub_prev    = ROOT_HUB_STATUS;
        state_next.port_prev   = DOWNSTREAM_PORT_STATUS;

        overrun = FRAME_END && !PERIODIC_DONE; // RULE3

        set_v[`UHCIS_IS_OVERRUN] = overrun; // RULE3
        set_v[`UHCIS_IS_FRAME_BEGIN] = FRAME_START; // RULE17
        // a resume the software ordered itself is not reported back
        set_v[`UHCIS_IS_RESUME] = RESUME_SIGNALING && // RULE18
                                  !state_reg.resume_prev && !SW_RESUME_CMD;
        set_v[`UHCIS_IS_FATAL] = 1'b0; // RULE14
        set_v[`UHCIS_IS_FRAME_WRAP] = state_reg.primed && // RULE12
            (FRAME_NUMBER[`UHCIS_FN_MSB] != state_reg.fn_msb_prev);
        set_v[`UHCIS_IS_ROOT_HUB] = hub_changed || (|port_changed); // RULE11

        // overrun counter, independent of the flag state
        if (overrun) begin
            state_next.ovr_count = state_reg.ovr_count + 2'b01; // RULE1 RULE2
        end

        // command/status write: only the reset bit is writable
        srst_start = bus.cs_wr && bus.wdata[`UHCIS_CS_RESET_BIT] && // RULE7
                     (state_reg.srst == UHCIS_SR_IDLE);

        // event flag write clears the ones, zeros are left alone
        if (bus.is_wr) begin
            clr_v = bus.wdata[`UHCIS_IS_MSB:0]; // RULE10
        end

        case (state_reg.srst)
            UHCIS_SR_IDLE: begin
                if (srst_start) begin
                    // hub and port logic sit outside this reset
                    state_next.srst          = UHCIS_SR_BUSY; // RULE4 RULE6
                    state_next.srst_count    = 16'h0000;
                    state_next.opreg_reset   = 1'b1; // RULE4
                    state_next.suspend_enter = 1'b1; // RULE4
                    state_next.ovr_count     = overrun ? 2'b01 : 2'b00;
                    clr_v = {(`UHCIS_IS_MSB+1){1'b1}}; // RULE4
                end
            end
            UHCIS_SR_BUSY: begin
                if (tick) begin
                    if (state_reg.srst_count == SRST_LAST) begin
                        state_next.srst = UHCIS_SR_IDLE; // RULE5
                        state_next.halt = 1'b0; // RULE13
                    end else begin
                        state_next.srst_count =
                            state_reg.srst_count + 16'h0001;
                    end
                end
            end
            default: begin
                state_next.srst = UHCIS_SR_IDLE;
            end
        endcase

        // halt holds until a soft reset has run its course
        if (SYSTEM_ERROR) begin
            state_next.halt = 1'b1; // RULE13
        end

        // set wins over a clear landing in the same cycle
        state_next.flags = ((state_reg.flags & ~clr_v) | set_v) & // RULE8
                           `UHCIS_IS_LIVE_MASK; // RULE20

        en_v = IRQ_ENABLE[`UHCIS_IS_MSB:0];
        state_next.irq = IRQ_ENABLE[`UHCIS_IE_MASTER] && // RULE19
                         (|(state_reg.flags & en_v)); // RULE9

        cs_word[`UHCIS_CS_RESET_BIT] = (state_reg.srst == UHCIS_SR_BUSY);
        cs_word[`UHCIS_CS_OVR_MSB:`UHCIS_CS_OVR_LSB] = state_reg.ovr_count;

        if (bus.cs_rd) begin
            state_next.rd_data  = cs_word; // RULE7 RULE20
            state_next.rd_valid = 1'b1;
        end else if (bus.is_rd) begin
            state_next.rd_data  = {25'h0000000, state_reg.flags}; // RULE20
            state_next.rd_valid = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg             <= '0;
            state_reg.srst        <= UHCIS_SR_IDLE;
            state_reg.ovr_count   <= 2'b00; // RULE1
            state_reg.flags       <= `UHCIS_IS_RESET_VALUE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign RD_DATA       = state_reg.rd_data;
    assign RD_VALID      = state_reg.rd_valid;
    assign IRQ           = state_reg.irq;
    assign OPREG_RESET   = state_reg.opreg_reset;
    assign SUSPEND_ENTER = state_reg.suspend_enter;
    assign HALT          = state_reg.halt;
endmodule

// ### test/tb_top.sv
`timescale 1ns/1ps
`include "uhcis_map.svh"

module tb_top;
    import uhcis_pkg::*;
    logic CLK = 1'b0, RSTN = 1'b0, FRAME_END = 1'b0, PERIODIC_DONE = 1'b0;
    logic FRAME_START = 1'b0, RESUME_SIGNALING = 1'b0, SW_RESUME_CMD = 1'b0;
    logic         SYSTEM_ERROR = 1'b0;
    logic [15:0]  FRAME_NUMBER = 16'h0;
    logic [31:0]  ROOT_HUB_STATUS = 32'h0;
    logic [31:0]  IRQ_ENABLE = 32'h0;
    uhcis_ports_t DOWNSTREAM_PORT_STATUS = '0;
    logic         CMD_STROBE, RD_VALID, IRQ, OPREG_RESET, SUSPEND_ENTER, HALT;
    logic [7:0]   CMD_CODE;
    logic [31:0]  WR_DATA, RD_DATA, d;
    logic         ok;
    int           n_fail = 0;
    int           total_checks = 0;
    logic [31:0]  ev_flags [10] = '{32'h04, 32'h20, 32'h20, 32'h40, 32'h40,
                                   32'h08, 32'h00, 32'h00, 32'h01, 32'h00};

    uhcis_host_model host (.CLK, .CMD_STROBE, .CMD_CODE, .WR_DATA,
                           .RD_DATA, .RD_VALID);
    uhcis_top #(.SRST_TICKS(3)) uut (.CLK, .RSTN, .CMD_STROBE, .CMD_CODE,
        .WR_DATA, .RD_DATA, .RD_VALID, .FRAME_END, .PERIODIC_DONE,
        .FRAME_START, .FRAME_NUMBER, .ROOT_HUB_STATUS, .DOWNSTREAM_PORT_STATUS,
        .RESUME_SIGNALING, .SW_RESUME_CMD, .SYSTEM_ERROR, .IRQ_ENABLE, .IRQ,
        .OPREG_RESET, .SUSPEND_ENTER, .HALT);

    always #25 CLK = ~CLK;

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string m);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h", $time, m, got);
        end
    endtask
    task automatic rdc(input logic [7:0] c, input logic [31:0] exp,
                       input string m);
        host.rd(c, d, ok);
        if (ok !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: read never answered", $time);
            summarize();
        end else begin
            check(d, exp, m);
        end
    endtask
    // settle on a falling edge, hand back on a rising one
    task automatic irq_is(input logic exp, input string m);
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        check({31'h0, IRQ}, {31'h0, exp}, m);
        @(posedge CLK);
    endtask
    task automatic ev(input int k);
        @(posedge CLK);
        case (k)
            0: FRAME_START <= 1'b1;
            1, 2: FRAME_NUMBER <= FRAME_NUMBER ^ 16'h8000;
            3: ROOT_HUB_STATUS <= ROOT_HUB_STATUS + 32'h1;
            4: DOWNSTREAM_PORT_STATUS[1] <= 32'h10;
            5: RESUME_SIGNALING <= 1'b1;
            6: begin
                SW_RESUME_CMD    <= 1'b1;
                RESUME_SIGNALING <= 1'b1;
            end
            9: SYSTEM_ERROR <= 1'b1;
            default: begin
                FRAME_END     <= 1'b1;
                PERIODIC_DONE <= (k == 7);
            end
        endcase
        @(posedge CLK);
        FRAME_START      <= 1'b0;
        FRAME_END        <= 1'b0;
        RESUME_SIGNALING <= 1'b0;
        SW_RESUME_CMD    <= 1'b0;
        SYSTEM_ERROR     <= 1'b0;
    endtask

    initial begin
        repeat (20) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (3) @(posedge CLK);
        rdc(`UHCIS_CODE_CS_RD, 32'h0, "cs reset");
        rdc(`UHCIS_CODE_IS_RD, 32'h0, "flags reset");
        for (int i = 1; i <= 5; i++) begin
            ev(8);
            rdc(`UHCIS_CODE_CS_RD, 32'(i % 4) << 16, "count");
        end
        ev(7);
        rdc(`UHCIS_CODE_CS_RD, 32'h10000, "count, list done");
        rdc(`UHCIS_CODE_IS_RD, 32'h1, "overrun flag");
        irq_is(1'b0, "irq, no enables");
        IRQ_ENABLE <= 32'h1;
        irq_is(1'b0, "irq, gate closed");
        IRQ_ENABLE <= 32'h80000004;
        irq_is(1'b0, "irq, other enable");
        IRQ_ENABLE <= 32'h80000001;
        irq_is(1'b1, "irq enabled");
        host.wr(`UHCIS_CODE_IS_WR, 32'h0);
        irq_is(1'b1, "irq after zero write");
        host.wr(`UHCIS_CODE_IS_WR, 32'h1);
        irq_is(1'b0, "irq after clear");
        host.wr(`UHCIS_CODE_IS_WR, 32'h7F);
        host.wr(`UHCIS_CODE_CS_WR, 32'hFFFFFFFE);
        rdc(`UHCIS_CODE_IS_RD, 32'h0, "flags set by write");
        rdc(`UHCIS_CODE_CS_RD, 32'h10000, "cs written");
        $display("test overrun and irq done");
        @(posedge CLK);
        IRQ_ENABLE <= 32'h8000007F;
        for (int k = 0; k < 10; k++) begin
            ev(k);
            rdc(`UHCIS_CODE_IS_RD, ev_flags[k],
                "event flags");
            host.wr(`UHCIS_CODE_IS_WR, 32'h7F);
        end
        @(negedge CLK);
        check({31'h0, HALT}, 32'h1, "halt on error");
        $display("test events done");
        host.wr(`UHCIS_CODE_CS_WR, 32'h1);
        repeat (2) @(negedge CLK);
        check({30'h0, OPREG_RESET, SUSPEND_ENTER}, 32'h3,
              "soft reset pulses");
        rdc(`UHCIS_CODE_CS_RD, 32'h1, "soft reset start");
        for (int n = 0; n < 30 && d !== 32'h0; n++)
            host.rd(`UHCIS_CODE_CS_RD, d, ok);
        check(d, 32'h0, "reset bit self clear");
        check({31'h0, ok}, 32'h1, "reset poll answered");
        check({31'h0, HALT}, 32'h0, "halt after reset");
        host.rd(8'h05, d, ok);
        check({31'h0, ok}, 32'h0, "unknown code");
        $display("test soft reset and codes done");
        summarize();
    end
endmodule

// ### test/uhcis_host_model.sv
`timescale 1ns/1ps

module uhcis_host_model (
    input  wire logic        CLK,
    output logic             CMD_STROBE,
    output logic [7:0]       CMD_CODE,
    output logic [31:0]      WR_DATA,
    input  wire logic [31:0] RD_DATA,
    input  wire logic        RD_VALID
);
    initial begin
        CMD_STROBE = 1'b0;
        CMD_CODE   = 8'h00;
        WR_DATA    = 32'h0;
    end
    // released lines scrambled so stale values never look valid
    task automatic issue(input logic [7:0] c, input logic [31:0] v);
        @(posedge CLK);
        CMD_STROBE <= 1'b1;
        CMD_CODE   <= c;
        WR_DATA    <= v;
        @(posedge CLK);
        CMD_STROBE <= 1'b0;
        CMD_CODE   <= ~c;
        WR_DATA    <= ~v;
    endtask
    task automatic wr(input logic [7:0] c, input logic [31:0] v);
        issue(c, v);
    endtask
    task automatic rd(input logic [7:0] c, output logic [31:0] d,
                      output logic ok);
        issue(c, 32'h0);
        ok = 1'b0;
        d  = 32'h0;
        repeat (6) begin
            @(negedge CLK);
            if (!ok && RD_VALID === 1'b1) begin
                ok = 1'b1;
                d  = RD_DATA;
            end
        end
    endtask
endmodule

// ### test/uhcis_top_props.sv
`timescale 1ns/1ps

module uhcis_top_props (
    input wire logic        CLK,
    input wire logic        RSTN,
    input wire logic        CMD_STROBE,
    input wire logic [7:0]  CMD_CODE,
    input wire logic [31:0] RD_DATA,
    input wire logic        RD_VALID,
    input wire logic        FRAME_END,
    input wire logic        PERIODIC_DONE,
    input wire logic [15:0] FRAME_NUMBER,
    input wire logic        SYSTEM_ERROR,
    input wire logic [31:0] IRQ_ENABLE,
    input wire logic        IRQ,
    input wire logic        OPREG_RESET,
    input wire logic        SUSPEND_ENTER,
    input wire logic        HALT
);
    // detectors arm only a few edges after release
    logic [2:0] up_reg;
    logic [2:0] quiet_reg;
    logic       live;
    assign live = up_reg == 3'h4;
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            up_reg    <= 3'h0;
            quiet_reg <= 3'h0;
        end else begin
            up_reg    <= live ? up_reg : up_reg + 3'h1;
            quiet_reg <= {quiet_reg[1:0], CMD_STROBE};
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence s_ovr_on;
        live && !HALT && FRAME_END && !PERIODIC_DONE && IRQ_ENABLE[31]
        && IRQ_ENABLE[0] ##1 IRQ_ENABLE[31] && IRQ_ENABLE[0];
    endsequence
    sequence s_wrap_on;
        live && !HALT && $changed(FRAME_NUMBER[15]) && IRQ_ENABLE[31]
        && IRQ_ENABLE[5] ##1 IRQ_ENABLE[31] && IRQ_ENABLE[5];
    endsequence
    a_gate_closed: assert property (
        !IRQ_ENABLE[31] ##1 !IRQ_ENABLE[31] |-> !IRQ)
        else $error("irq with master gate closed");
    a_overrun_irq: assert property (
        s_ovr_on |=> IRQ) else $error("overrun gave no irq");
    a_wrap_irq: assert property (
        s_wrap_on |=> IRQ) else $error("frame wrap gave no irq");
    a_read_answer: assert property (
        CMD_STROBE && CMD_CODE inside {8'h02, 8'h03} |-> ##[2:3] RD_VALID)
        else $error("read not answered");
    a_reserved_zero: assert property (
        RD_VALID |-> (RD_DATA & ~32'h0003006D) == 32'h0)
        else $error("reserved or fatal bit read nonzero");
    a_reset_pair: assert property (
        $rose(OPREG_RESET) |-> SUSPEND_ENTER ##1 !OPREG_RESET && !SUSPEND_ENTER)
        else $error("soft reset pulses wrong");
    a_halt_error: assert property (
        live && SYSTEM_ERROR && !OPREG_RESET |-> ##[1:2] HALT)
        else $error("no halt on system error");
    // hardware never clears: irq holds while nothing was written
    a_irq_hold: assert property (
        IRQ && !CMD_STROBE && quiet_reg == 3'h0 && $stable(IRQ_ENABLE)
        |=> IRQ) else $error("irq dropped without software clear");
endmodule

bind uhcis_top uhcis_top_props chk (
    .CLK, .RSTN, .CMD_STROBE, .CMD_CODE, .RD_DATA, .RD_VALID, .FRAME_END,
    .PERIODIC_DONE, .FRAME_NUMBER, .SYSTEM_ERROR, .IRQ_ENABLE, .IRQ,
    .OPREG_RESET, .SUSPEND_ENTER, .HALT
);
